// *** sarsr_map.vh ***
// Purpose: shared constants for the serial conversion-control and readout block
// Assumes: 40 MHz system clock
// Notes:   times in ns, cycle counts derived in the main module
`ifndef SARSR_MAP_VH
`define SARSR_MAP_VH

// ----------------------------------------
// result format
// ----------------------------------------
`define SARSR_RES_W        14
`define SARSR_CODE_ZERO    14'h0000
`define SARSR_CODE_MID     14'h2000
`define SARSR_CODE_FULL    14'h3FFF

// ----------------------------------------
// timing
// ----------------------------------------
`define SARSR_CLK_NS       25
`define SARSR_TCONV_MIN_NS 500
`define SARSR_TCONV_MAX_NS 1500
`define SARSR_CNT_W        16

`endif

// *** sarsr_edge.v ***
// Purpose: two-flop synchroniser with rise and fall pulses for one pin
// Assumes: pin is asynchronous to i_clk
// Notes:   first flop is read only by the second flop
module sarsr_edge
(
  input  wire i_clk,
  input  wire i_nrst,
  input  wire i_pin,
  output wire o_lvl,
  output wire o_rise,
  output wire o_fall
);

  reg meta_r;
  reg sync_r;
  reg prev_r;

  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign o_lvl  = sync_r;
  assign o_rise = sync_r & ~prev_r;
  assign o_fall = ~sync_r & prev_r;

endmodule

// *** sarsr_readout.v ***
// Purpose: conversion control and serial readout of a 14-bit converter
// Assumes: host pins sampled by i_clk; converter result given on i_conv_code
// Notes:   conversion time modelled by a counter; result latched at conversion end
`include "sarsr_map.vh"
module sarsr_readout
#(
  parameter TCONV_MIN_NS = `SARSR_TCONV_MIN_NS,
  parameter TCONV_MAX_NS = `SARSR_TCONV_MAX_NS
)
(
  input  wire                   i_clk,
  input  wire                   i_nrst,
  input  wire                   i_conversion_start_input,
  input  wire                   i_sclk,
  input  wire                   i_sdi,
  input  wire [`SARSR_RES_W-1:0] i_conv_code,
  output wire                   o_sdo,
  output wire                   o_sdo_oe,
  output wire                   o_shutdown,
  output wire                   o_converting,
  output wire                   o_chain_mode,
  output wire                   o_busy_en
);

  // ----------------------------------------
  // timing constants
  // ----------------------------------------
  // least time rounds up, longest rounds down; conversion ends at max
  localparam [`SARSR_CNT_W-1:0] CONV_MIN_CYC =
    (TCONV_MIN_NS + `SARSR_CLK_NS - 1) / `SARSR_CLK_NS;
  localparam [`SARSR_CNT_W-1:0] CONV_MAX_CYC =
    (TCONV_MAX_NS / `SARSR_CLK_NS < 1) ? 1 : TCONV_MAX_NS / `SARSR_CLK_NS;
  localparam [4:0] BITS_NOBUSY = 5'd14;
  localparam [4:0] BITS_BUSY   = 5'd15;

  // one-hot states
  localparam [2:0] ST_ACQ  = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_SHDN = 3'b100;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire cnv_lvl;
  wire cnv_rise;
  wire cnv_fall;
  wire sck_lvl;
  wire sck_fall;
  wire sdi_lvl;

  sarsr_edge u_cnv
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pin  (i_conversion_start_input),
    .o_lvl  (cnv_lvl),
    .o_rise (cnv_rise),
    .o_fall (cnv_fall)
  );

  sarsr_edge u_sck
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pin  (i_sclk),
    .o_lvl  (sck_lvl),
    .o_rise (),
    .o_fall (sck_fall)
  );

  sarsr_edge u_sdi
  (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .i_pin  (i_sdi),
    .o_lvl  (sdi_lvl),
    .o_rise (),
    .o_fall ()
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [2:0]              state_r;
  reg [2:0]              state_nxt;
  reg [`SARSR_CNT_W-1:0] cnt_r;
  reg                    chain_r;
  reg                    busy_en_r;
  reg [`SARSR_RES_W-1:0] shreg_r;
  reg                    sdo_r;
  reg                    oe_r;
  reg [4:0]              nbit_r;
  reg                    busy_pend_r;
  reg                    rd_open_r;

  wire conv_done = (state_r == ST_CONV) && (cnt_r >= CONV_MAX_CYC - 1'b1);

  // the count nbit is parked at after a select-mode readout depends on whether a busy bit leads
  wire [4:0] bit_lim = busy_en_r ? BITS_BUSY : BITS_NOBUSY;

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_ACQ:
      begin
        if (cnv_rise)
          state_nxt = ST_CONV;
        else if (cnv_fall && sck_lvl)
          state_nxt = ST_SHDN;
      end
      ST_CONV:
      begin
        // start line changes do not abort the conversion
        if (conv_done)
          state_nxt = ST_ACQ;
      end
      ST_SHDN:
      begin
        if (cnv_fall && !sck_lvl)
          state_nxt = ST_ACQ;
      end
      default:
        state_nxt = ST_ACQ;
    endcase
  end

  // ----------------------------------------
  // control and shifter
  // ----------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_r     <= ST_ACQ;
      cnt_r       <= {`SARSR_CNT_W{1'b0}};
      chain_r     <= 1'b0;
      busy_en_r   <= 1'b0;
      shreg_r     <= `SARSR_CODE_ZERO;
      sdo_r       <= 1'b0;
      oe_r        <= 1'b0;
      nbit_r      <= 5'd0;
      busy_pend_r <= 1'b0;
      rd_open_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r == ST_CONV)
        cnt_r <= cnt_r + 1'b1;
      else
        cnt_r <= {`SARSR_CNT_W{1'b0}};

      if (state_r == ST_ACQ && cnv_rise)
      begin
        chain_r     <= ~sdi_lvl;
        busy_en_r   <= ~sdi_lvl & sck_lvl;
        busy_pend_r <= 1'b0;
        rd_open_r   <= 1'b0;
        nbit_r      <= 5'd0;
        oe_r        <= ~sdi_lvl;
        sdo_r       <= 1'b0;
      end
      else if (conv_done)
      begin
        // straight binary result straight from the converter
        shreg_r <= i_conv_code;
        nbit_r  <= 5'd0;
        if (chain_r)
        begin
          oe_r <= 1'b1;
          if (busy_en_r)
          begin
            // busy output waits for the upstream part's busy
            busy_pend_r <= 1'b1;
            sdo_r       <= 1'b0;
          end
          else
            sdo_r <= i_conv_code[`SARSR_RES_W-1];
        end
        else if (!cnv_lvl || !sdi_lvl)
        begin
          busy_en_r <= 1'b1;
          oe_r      <= 1'b1;
          sdo_r     <= 1'b0;
          rd_open_r <= 1'b1;
        end
        else
        begin
          busy_en_r <= 1'b0;
          rd_open_r <= 1'b0;
        end
      end
      else if (state_r == ST_ACQ && chain_r)
      begin
        oe_r <= 1'b1;
        if (busy_pend_r)
        begin
          if (sdi_lvl)
          begin
            sdo_r       <= 1'b1;
            busy_pend_r <= 1'b0;
          end
        end
        else if (sck_fall)
        begin
          if (busy_en_r && nbit_r == 5'd0)
          begin
            // busy bit is flushed, not chained
            sdo_r  <= shreg_r[`SARSR_RES_W-1];
            nbit_r <= 5'd1;
          end
          else
          begin
            shreg_r <= {shreg_r[`SARSR_RES_W-2:0], sdi_lvl};
            sdo_r   <= shreg_r[`SARSR_RES_W-2];
          end
        end
        else if (!cnv_lvl && !sdi_lvl && state_nxt == ST_ACQ && cnv_fall)
          sdo_r <= 1'b0;
      end
      else if (state_r == ST_ACQ)
      begin
        // select modes: start and sdi both high end the readout
        if (busy_en_r && rd_open_r && cnv_lvl && sdi_lvl)
        begin
          oe_r      <= 1'b0;
          rd_open_r <= 1'b0;
        end
        else if (!busy_en_r && !rd_open_r && nbit_r == 5'd0
                 && (!cnv_lvl || !sdi_lvl))
        begin
          // 3-wire: start low, 4-wire: sdi low opens readout with msb
          oe_r      <= 1'b1;
          sdo_r     <= shreg_r[`SARSR_RES_W-1];
          rd_open_r <= 1'b1;
          nbit_r    <= 5'd1;
        end
        else if (rd_open_r && sck_fall)
        begin
          // nbit counts data bits already shown: the last one must stand a full sclk period
          if (nbit_r >= BITS_NOBUSY)
          begin
            oe_r      <= 1'b0;
            rd_open_r <= 1'b0;
            nbit_r    <= bit_lim;
          end
          else if (busy_en_r && nbit_r == 5'd0)
          begin
            // first fall flushes the busy bit and shows the msb unshifted
            sdo_r  <= shreg_r[`SARSR_RES_W-1];
            nbit_r <= 5'd1;
          end
          else
          begin
            nbit_r  <= nbit_r + 1'b1;
            sdo_r   <= shreg_r[`SARSR_RES_W-2];
            shreg_r <= {shreg_r[`SARSR_RES_W-2:0], 1'b0};
          end
        end
        else if (rd_open_r && !busy_en_r && cnv_lvl && sdi_lvl && nbit_r != 5'd0
                 && !(!cnv_lvl || !sdi_lvl))
        begin
          oe_r      <= 1'b0;
          rd_open_r <= 1'b0;
        end
        else if (!rd_open_r && !cnv_lvl && !sdi_lvl)
        begin
          oe_r  <= 1'b1;
          sdo_r <= 1'b0;
        end
        else if (!rd_open_r && oe_r && (cnv_lvl || sdi_lvl))
          oe_r <= 1'b0;
      end
      else if (state_r == ST_SHDN)
        oe_r <= chain_r;
    end
  end

  assign o_sdo        = sdo_r;
  assign o_sdo_oe     = oe_r;
  assign o_shutdown   = (state_r == ST_SHDN);
  assign o_converting = (state_r == ST_CONV);
  assign o_chain_mode = chain_r;
  assign o_busy_en    = busy_en_r;

endmodule

// *** sarsr_props.sv ***
// Purpose: pin timing checks for the readout block
// Assumes: pins sampled by i_clk, pin edges seen about 3 cycles late
// Notes:   sclk half period of at least 4 cycles
module sarsr_props
#(
  parameter TCONV_MAX_NS = 1500
)
(
  input wire i_clk,
  input wire i_nrst,
  input wire i_conversion_start_input,
  input wire i_sclk,
  input wire i_sdi,
  input wire o_sdo,
  input wire o_sdo_oe,
  input wire o_shutdown,
  input wire o_converting,
  input wire o_chain_mode,
  input wire o_busy_en
);
  localparam int CV_LO = TCONV_MAX_NS / 25 - 9;
  localparam int CV_HI = TCONV_MAX_NS / 25 - 5;
  wire cs   = i_conversion_start_input;
  wire idle = !o_converting && !o_shutdown;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_mode; $rose(cs) && idle |-> ##5 (o_chain_mode == !$past(i_sdi, 5)); endproperty
  a_mode: assert property (p_mode) else $error("mode not taken from sdi");
  property p_cbusy; $rose(cs) && !i_sdi && idle |-> ##5 (o_busy_en == $past(i_sclk, 5)); endproperty
  a_cbusy: assert property (p_cbusy) else $error("chain busy enable wrong");
  property p_start; $rose(cs) && i_sdi && idle |-> ##[2:6] (o_converting && !o_sdo_oe); endproperty
  a_start: assert property (p_start) else $error("conversion start wrong");
  // length fixed even when start toggles mid conversion
  property p_len; $rose(o_converting) |-> o_converting[*8] ##[CV_LO:CV_HI] !o_converting; endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_sbusy;
    $fell(o_converting) && !o_chain_mode && !$past(cs, 4) |-> ##[0:2] (o_busy_en && o_sdo_oe && !o_sdo);
  endproperty
  a_sbusy: assert property (p_sbusy) else $error("busy bit missing");
  property p_nobusy;
    $fell(o_converting) && !o_chain_mode && $past(cs, 4) && $past(i_sdi, 4) |-> ##[0:2] (!o_busy_en && !o_sdo_oe);
  endproperty
  a_nobusy: assert property (p_nobusy) else $error("busy shown when disabled");
  property p_low; (!cs && !i_sdi && !o_chain_mode && !o_shutdown)[*5] |-> o_sdo_oe && !o_sdo; endproperty
  a_low: assert property (p_low) else $error("sdo not driven low");
  property p_hold; $fell(i_sclk) |-> $stable({o_sdo_oe, o_sdo})[*3]; endproperty
  a_hold: assert property (p_hold) else $error("sdo moved at sclk fall");
  property p_sleep; $fell(cs) && i_sclk && idle |-> ##[2:6] o_shutdown; endproperty
  a_sleep: assert property (p_sleep) else $error("shutdown not entered");
  property p_wake; $fell(cs) && !i_sclk && o_shutdown |-> ##[2:6] !o_shutdown; endproperty
  a_wake: assert property (p_wake) else $error("shutdown not left");
  c_busy: cover property ($fell(o_converting) && o_busy_en);
  c_chain: cover property ($rose(o_chain_mode));
  c_sleep: cover property ($rose(o_shutdown));
endmodule
bind sarsr_readout sarsr_props #(.TCONV_MAX_NS(TCONV_MAX_NS)) sarsr_props_inst (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_conversion_start_input(i_conversion_start_input),
  .i_sclk(i_sclk), .i_sdi(i_sdi), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_shutdown(o_shutdown),
  .o_converting(o_converting), .o_chain_mode(o_chain_mode), .o_busy_en(o_busy_en));

// *** sarsr_host.sv ***
// Purpose: host end of the serial link, captures sdo on sclk falls
// Assumes: sdo line has a pull-up when floated
// Notes:   o_done rises once i_len bits are in
module sarsr_host
(
  input  wire         i_sclk,
  input  wire         i_clr,
  input  wire  [5:0]  i_len,
  input  wire         i_sdo,
  input  wire         i_sdo_oe,
  output logic [31:0] o_word,
  output wire         o_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] n_r;
  wire        line = i_sdo_oe ? i_sdo : 1'b1;
  assign o_done = (i_len != 6'h0) && (n_r == i_len);
  // falling edge gives the most setup margin
  always @(negedge i_sclk or posedge i_clr)
    if (i_clr)
    begin
      n_r <= 6'h0;
      o_word <= 32'h0;
    end
    else
    begin
      n_r <= n_r + 6'h1;
      o_word <= {o_word[30:0], line};
    end
endmodule

// *** tb.sv ***
// Purpose: self-checking bench for the serial readout block
// Assumes: host pins change on i_clk rising edges, sclk period 200 ns
// Notes:   short conversion times keep the run brief
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk  = 1'b0;
  logic        i_nrst = 1'b0;
  logic        cs     = 1'b0;
  logic        sk     = 1'b0;
  logic        sdi    = 1'b1;
  logic        clr    = 1'b1;
  logic [5:0]  len    = 6'h0;
  logic [13:0] code   = 14'h0;
  logic [15:0] rnd    = 16'hDF00;
  wire         sdo, oe, sd, conv, chain, busy, done;
  wire  [31:0] word;
  logic [31:0] q[$];
  int          n_mismatch = 0;
  int          compares   = 0;
  always #12.5 i_clk = ~i_clk;
  sarsr_readout #(.TCONV_MIN_NS(200), .TCONV_MAX_NS(500)) sarsr_readout_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_conversion_start_input(cs), .i_sclk(sk),
    .i_sdi(sdi), .i_conv_code(code), .o_sdo(sdo), .o_sdo_oe(oe), .o_shutdown(sd),
    .o_converting(conv), .o_chain_mode(chain), .o_busy_en(busy));
  sarsr_host sarsr_host_inst (.i_sclk(sk), .i_clr(clr), .i_len(len), .i_sdo(sdo),
    .i_sdo_oe(oe), .o_word(word), .o_done(done));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk);
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // d: sdi at start rise, s: sclk at start rise, cc/cr: start level in conversion/readout
  task automatic frame(input logic d, s, cc, cr, dr, input logic [13:0] up, cd, input int n);
    logic [27:0] sh;
    int          t;
    sh = {up, {14{dr}}};
    tick(1);
    code <= cd;
    clr <= 1'b1;
    len <= n[5:0];
    cs <= 1'b0;
    q.push_back(n == 28 ? {4'h0, cd, up} : {17'h0, n == 15 && !d, cd});
    tick(6);
    sdi <= d;
    sk <= s;
    tick(6);
    cs <= 1'b1;
    tick(6);
    sk <= 1'b0;
    cs <= cc;
    tick(1);
    clr <= 1'b0;
    for (t = 0; t < 200 && conv !== 1'b0; t++)
      tick(1);
    if (t == 200)
    begin
      n_mismatch++;
      close_out();
    end
    cs <= cr;
    sdi <= dr;
    tick(8);
    chk(chain, !d);
    chk(busy, d ? !cc : s);
    for (t = 0; t < n; t++)
    begin
      sk <= 1'b1;
      sdi <= sh[27];
      sh = sh << 1;
      tick(4);
      sk <= 1'b0;
      tick(4);
    end
    tick(6);
    chk(oe, !d);
    rnd = lfsr(rnd);
  endtask
  always @(posedge done)
    if (q.size() > 0)
      chk(word, q.pop_front());
  initial
  begin
    tick(8);
    i_nrst <= 1'b1;
    tick(4);
    frame(1, 0, 1, 0, 1, 14'h3FFF, 14'h0000, 14);
    frame(1, 0, 1, 0, 1, 14'h3FFF, 14'h2000, 14);
    frame(1, 0, 1, 0, 1, 14'h3FFF, 14'h3FFF, 14);
    frame(1, 0, 0, 0, 1, 14'h3FFF, rnd[13:0], 15);
    frame(1, 0, 1, 1, 0, 14'h0000, rnd[13:0], 14);
    frame(0, 0, 1, 1, 0, rnd[15:2], rnd[13:0], 28);
    frame(0, 1, 1, 1, 1, 14'h3FFF, rnd[13:0], 15);
    tick(1);
    sk <= 1'b1;
    tick(6);
    cs <= 1'b0;
    tick(8);
    chk(sd, 1'b1);
    cs <= 1'b1;
    tick(6);
    sk <= 1'b0;
    tick(30);
    cs <= 1'b0;
    tick(8);
    chk(sd, 1'b0);
    chk(q.size(), 0);
    close_out();
  end
endmodule
